// *** design/tchk_buf2.sv ***
/*
  Two-entry buffer for staging-RAM writes. Assumes the filling side
  pushes only while in_ready is high; the head is a register.
*/
`timescale 1ns/1ns
module tchk_buf2 (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic in_valid,
  input wire tchk_pkg::tchk_ram_word_t in_word,
  output logic in_ready,
  output logic out_valid,
  output tchk_pkg::tchk_ram_word_t out_word,
  input wire logic out_ready,
  output logic [1:0] count
);
  import tchk_pkg::*;

  logic tail_valid;
  tchk_ram_word_t tail_word;
  logic push;
  logic pop;

  assign in_ready = !tail_valid;
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign count = {1'b0, out_valid} + {1'b0, tail_valid};

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      out_valid <= 1'b0;
      tail_valid <= 1'b0;
    end else if (pop) begin
      out_valid <= tail_valid || push;
      tail_valid <= 1'b0;
    end else if (push) begin
      out_valid <= 1'b1;
      tail_valid <= out_valid;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      out_word <= '0;
      tail_word <= '0;
    end else begin
      if (pop) begin
        out_word <= tail_valid ? tail_word : in_word;
      end else if (push && !out_valid) begin
        out_word <= in_word;
      end
      if (push && out_valid && !pop) begin
        tail_word <= in_word;
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_head_holds;
    out_valid && !out_ready |=> out_valid && $stable(out_word);
  endproperty
  a_head_holds: assert property (p_head_holds)
    else $error("buffer head changed while stalled");

  property p_full_refuses;
    out_valid && tail_valid |-> !in_ready;
  endproperty
  a_full_refuses: assert property (p_full_refuses)
    else $error("buffer full but ready");

endmodule : tchk_buf2

// *** design/tchk_crc16.sv ***
/*
  Byte-serial CRC16 checker. Assumes the CRC field is the last two
  bytes of the packet, so a good packet leaves a zero remainder.
*/
`timescale 1ns/1ns
module tchk_crc16 (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic en,
  input wire logic first,
  input wire logic [7:0] data,
  output logic residue_zero
);
  import tchk_pkg::*;

  logic [15:0] crc;
  logic [15:0] seed;
  logic [15:0] next_crc;

  function automatic logic [15:0] crc_step(input logic [15:0] c,
                                           input logic [7:0] d);
    logic [15:0] r;
    logic fb;
    r = c;
    for (int i = 7; i >= 0; i--) begin
      fb = r[15] ^ d[i];
      r = {r[14:0], 1'b0};
      if (fb) begin
        r = r ^ CRC_POLY;
      end
    end
    return r;
  endfunction : crc_step

  assign seed = first ? CRC_INIT : crc;
  assign next_crc = crc_step(seed, data);
  assign residue_zero = (next_crc == 16'h0000);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      crc <= CRC_INIT;
    end else if (en) begin
      crc <= next_crc;
    end
  end

endmodule : tchk_crc16

// *** design/tchk_interp.sv ***
/*
  Telecommand interpreter: housekeeping report switching and memory
  load into staging RAM with commit on a confirmation load. Assumes
  one packet per rx_first..rx_last burst, and an outside decoder of
  the initialization command that pulses upload_enter.
*/
`timescale 1ns/1ns

module tchk_interp #(
  parameter logic [31:0] CONFIRM_ADDR = tchk_pkg::DEF_CONFIRM_ADDR
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  input wire logic rx_first,
  input wire logic rx_last,
  output logic rx_ready,
  input wire logic upload_enter,
  input wire logic [7:0] upload_blocks,
  output logic hk_report_enabled,
  output logic upload_active,
  output logic ram_wr_valid,
  output tchk_pkg::tchk_ram_word_t ram_wr_word,
  input wire logic ram_wr_ready,
  output logic eeprom_commit,
  output logic report_incorrect_cmd,
  output logic report_upload_done,
  output logic report_anomaly
);
  import tchk_pkg::*;

  // ****************************************************************
  // Reset release
  // ****************************************************************
  logic rst_meta;
  logic rst_n;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // ****************************************************************
  // Byte position and captured fields
  // ****************************************************************
  logic accept;
  logic pkt_end;
  logic [15:0] idx;
  logic [15:0] cur_idx;
  logic [15:0] total;
  logic [7:0] f_dfh0;
  logic [7:0] f_type;
  logic [7:0] f_sub;
  logic [7:0] f_dfh3;
  logic [7:0] f_sel;
  logic [7:0] f_sid;
  logic [31:0] f_addr;
  logic [15:0] f_len;
  logic [7:0] f_hi;
  logic [7:0] word_cnt;
  tchk_mode_t mode;
  logic [7:0] expected;
  logic [7:0] valid_cnt;

  assign accept = rx_valid && rx_ready;
  assign pkt_end = accept && rx_last;
  assign cur_idx = rx_first ? 16'h0000 : idx;
  assign total = cur_idx + 16'h0001;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      idx <= 16'h0000;
    end else if (accept) begin
      if (rx_last) begin
        idx <= 16'h0000;
      end else if (cur_idx != 16'hffff) begin
        // Saturate so an endless burst cannot alias a short packet
        idx <= cur_idx + 16'h0001;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      f_dfh0 <= 8'h00;
      f_type <= 8'h00;
      f_sub <= 8'h00;
      f_dfh3 <= 8'h00;
      f_sel <= 8'h00;
      f_sid <= 8'h00;
      f_addr <= 32'h0000_0000;
      f_len <= 16'h0000;
    end else if (accept && rx_first) begin
      // Stale fields of a longer packet must not leak into this one
      f_dfh0 <= 8'h00;
      f_type <= 8'h00;
      f_sub <= 8'h00;
      f_dfh3 <= 8'h00;
      f_sel <= 8'h00;
      f_sid <= 8'h00;
      f_addr <= 32'h0000_0000;
      f_len <= 16'h0000;
    end else if (accept) begin
      case (cur_idx)
        POS_DFH0: f_dfh0 <= rx_data;
        POS_TYPE: f_type <= rx_data;
        POS_SUB: f_sub <= rx_data;
        POS_DFH3: f_dfh3 <= rx_data;
        POS_SEL: f_sel <= rx_data;
        POS_SID: f_sid <= rx_data;
        POS_LEN0: f_len <= {rx_data, f_len[7:0]};
        POS_LEN1: f_len <= {f_len[15:8], rx_data};
        default: begin
          if (cur_idx >= POS_ADDR0 && cur_idx <= POS_ADDR3) begin
            f_addr <= {f_addr[23:0], rx_data};
          end
        end
      endcase
    end
  end

  // ****************************************************************
  // Command decoding
  // ****************************************************************
  function automatic logic is_cmd(input logic [7:0] typ,
                                  input logic [7:0] sub,
                                  input logic [7:0] want_typ,
                                  input logic [7:0] want_sub);
    return (typ == want_typ) && (sub == want_sub);
  endfunction : is_cmd

  logic hdr_ok;
  logic crc_ok;
  logic is_hk_en;
  logic is_hk_dis;
  logic load_fields_ok;
  logic is_load;
  logic is_confirm;
  logic [15:0] load_total;

  assign hdr_ok = (f_dfh0 == DFH_FIRST) && (f_dfh3 == DFH_LAST);
  assign load_total = LOAD_PKT_BASE + {f_len[14:0], 1'b0};

  assign is_hk_en = hdr_ok && is_cmd(f_type, f_sub, SVC_HK, SUB_HK_ENABLE)
                    && (total == HK_PKT_LEN) && (f_sid == HK_SID_VALUE);
  assign is_hk_dis = hdr_ok
                     && is_cmd(f_type, f_sub, SVC_HK, SUB_HK_DISABLE)
                     && (total == HK_PKT_LEN) && (f_sid == HK_SID_VALUE);
  assign load_fields_ok = hdr_ok
                          && is_cmd(f_type, f_sub, SVC_MEMORY,
                                    SUB_MEMORY_LOAD)
                          && (f_sel == MEM_SELECTOR_VALUE)
                          && (f_sid == MEM_BLOCKS_VALUE)
                          && (f_len <= LOAD_MAX_WORDS);
  assign is_load = load_fields_ok && (total == load_total);
  assign is_confirm = is_load && (f_addr == CONFIRM_ADDR);

  tchk_crc16 u_crc (
    .clk(clk),
    .rst_n(rst_n),
    .en(accept),
    .first(rx_first),
    .data(rx_data),
    .residue_zero(crc_ok)
  );

  // ****************************************************************
  // Load data into staging RAM
  // ****************************************************************
  logic [15:0] doff;
  logic in_data;
  logic stage_ok;
  logic push;
  logic buf_in_ready;
  logic [1:0] buf_count;
  tchk_ram_word_t push_word;

  assign doff = cur_idx - POS_DATA0;
  assign in_data = (cur_idx >= POS_DATA0)
                   && (doff < {f_len[14:0], 1'b0});
  assign stage_ok = (mode == TCHK_UPLOAD) && load_fields_ok
                    && (f_addr != CONFIRM_ADDR);
  assign push = accept && in_data && doff[0] && stage_ok;
  assign push_word.addr = f_addr + {24'h00_0000, word_cnt};
  assign push_word.data = {f_hi, rx_data};

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      f_hi <= 8'h00;
      word_cnt <= 8'h00;
    end else if (accept && rx_first) begin
      word_cnt <= 8'h00;
    end else begin
      if (accept && in_data && !doff[0]) begin
        f_hi <= rx_data;
      end
      if (push) begin
        word_cnt <= word_cnt + 8'h01;
      end
    end
  end

  tchk_buf2 u_buf (
    .clk(clk),
    .rst_n(rst_n),
    .in_valid(push),
    .in_word(push_word),
    .in_ready(buf_in_ready),
    .out_valid(ram_wr_valid),
    .out_word(ram_wr_word),
    .out_ready(ram_wr_ready),
    .count(buf_count)
  );

  // Ready only with an empty buffer: one word of slack always remains,
  // at the price of halving the rate of data bytes even while RAM keeps up
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_ready <= 1'b0;
    end else begin
      rx_ready <= (buf_count == 2'b00) && !push;
    end
  end

  // ****************************************************************
  // Mode, counts and reports
  // ****************************************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mode <= TCHK_NORMAL;
      upload_active <= 1'b0;
      expected <= 8'h00;
      valid_cnt <= 8'h00;
      hk_report_enabled <= RST_HK_ENABLED;
      eeprom_commit <= 1'b0;
      report_incorrect_cmd <= 1'b0;
      report_upload_done <= 1'b0;
      report_anomaly <= 1'b0;
    end else begin
      eeprom_commit <= 1'b0;
      report_incorrect_cmd <= 1'b0;
      report_upload_done <= 1'b0;
      report_anomaly <= 1'b0;
      case (mode)
        TCHK_NORMAL: begin
          if (pkt_end && crc_ok) begin
            if (is_load) begin
              report_incorrect_cmd <= 1'b1;
            end else if (is_hk_en) begin
              hk_report_enabled <= 1'b1;
            end else if (is_hk_dis) begin
              hk_report_enabled <= 1'b0;
            end
          end else if (!pkt_end && upload_enter) begin
            mode <= TCHK_UPLOAD;
            upload_active <= 1'b1;
            expected <= upload_blocks;
            valid_cnt <= 8'h00;
          end
        end
        TCHK_UPLOAD: begin
          if (pkt_end && !crc_ok) begin
            report_anomaly <= 1'b1;
            mode <= TCHK_NORMAL;
            upload_active <= 1'b0;
          end else if (pkt_end && is_confirm) begin
            mode <= TCHK_NORMAL;
            upload_active <= 1'b0;
            if (valid_cnt == expected) begin
              eeprom_commit <= 1'b1;
              report_upload_done <= 1'b1;
            end else begin
              report_anomaly <= 1'b1;
            end
          end else if (pkt_end && is_load) begin
            if (valid_cnt == expected) begin
              report_anomaly <= 1'b1;
              mode <= TCHK_NORMAL;
              upload_active <= 1'b0;
            end else begin
              valid_cnt <= valid_cnt + 8'h01;
            end
          end else if (pkt_end && (is_hk_en || is_hk_dis)) begin
            report_incorrect_cmd <= 1'b1;
          end
        end
        default: begin
          mode <= TCHK_NORMAL;
          upload_active <= 1'b0;
        end
      endcase
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_good_end;
    pkt_end && crc_ok;
  endsequence

  sequence s_upload_good_end;
    s_good_end ##0 (mode == TCHK_UPLOAD);
  endsequence

  property p_hk_on;
    s_good_end ##0 (is_hk_en && mode == TCHK_NORMAL)
      |=> hk_report_enabled;
  endproperty
  a_hk_on: assert property (p_hk_on)
    else $error("enable command did not enable reporting");

  property p_hk_off;
    s_good_end ##0 (is_hk_dis && mode == TCHK_NORMAL)
      |=> !hk_report_enabled;
  endproperty
  a_hk_off: assert property (p_hk_off)
    else $error("disable command did not disable reporting");

  property p_crc_ignored;
    pkt_end && !crc_ok && mode == TCHK_NORMAL
      |=> $stable(hk_report_enabled) && !report_incorrect_cmd;
  endproperty
  a_crc_ignored: assert property (p_crc_ignored)
    else $error("bad CRC packet was obeyed");

  property p_stage_upload_only;
    push |-> mode == TCHK_UPLOAD && buf_in_ready;
  endproperty
  a_stage_upload_only: assert property (p_stage_upload_only)
    else $error("staging write outside upload state");

  property p_reject_load;
    s_good_end ##0 (is_load && mode == TCHK_NORMAL)
      |=> report_incorrect_cmd && !upload_active;
  endproperty
  a_reject_load: assert property (p_reject_load)
    else $error("load outside upload state not rejected");

  property p_hk_refused;
    s_upload_good_end ##0 (is_hk_en || is_hk_dis)
      |=> report_incorrect_cmd && $stable(hk_report_enabled);
  endproperty
  a_hk_refused: assert property (p_hk_refused)
    else $error("housekeeping command obeyed in upload state");

  property p_commit_count;
    eeprom_commit |-> $past(valid_cnt) == $past(expected)
                      && report_upload_done && !upload_active;
  endproperty
  a_commit_count: assert property (p_commit_count)
    else $error("commit without matching block count");

  property p_commit_cause;
    eeprom_commit |-> $past(is_confirm && pkt_end && crc_ok);
  endproperty
  a_commit_cause: assert property (p_commit_cause)
    else $error("commit without confirmation load");

  property p_crc_abort;
    pkt_end && !crc_ok && mode == TCHK_UPLOAD
      |=> report_anomaly && !eeprom_commit ##1 !eeprom_commit;
  endproperty
  a_crc_abort: assert property (p_crc_abort)
    else $error("CRC error in upload did not abort");

  property p_stage_fields;
    push |-> f_sel == MEM_SELECTOR_VALUE && f_len <= LOAD_MAX_WORDS
             && {8'h00, word_cnt} < f_len;
  endproperty
  a_stage_fields: assert property (p_stage_fields)
    else $error("staging write beyond declared load");

  property p_discard;
    pkt_end && crc_ok && !is_load && !is_hk_en && !is_hk_dis
      |=> $stable(hk_report_enabled) && $stable(mode)
          && !report_incorrect_cmd && !report_anomaly;
  endproperty
  a_discard: assert property (p_discard)
    else $error("unknown command changed state");

endmodule : tchk_interp

// *** design/tchk_pkg.sv ***
/*
  Shared constants and types of the telecommand interpreter for
  housekeeping switching and memory load. Assumes byte-wide packets
  that hold the whole telecommand, header first, CRC last.
*/
package tchk_pkg;

  // ****************************************************************
  // Packet layout, as byte positions from the first header byte
  // ****************************************************************
  localparam logic [15:0] POS_DFH0 = 16'h0006;
  localparam logic [15:0] POS_TYPE = 16'h0007;
  localparam logic [15:0] POS_SUB = 16'h0008;
  localparam logic [15:0] POS_DFH3 = 16'h0009;
  localparam logic [15:0] POS_SEL = 16'h000a;
  localparam logic [15:0] POS_SID = 16'h000b;
  localparam logic [15:0] POS_ADDR0 = 16'h000c;
  localparam logic [15:0] POS_ADDR3 = 16'h000f;
  localparam logic [15:0] POS_LEN0 = 16'h0010;
  localparam logic [15:0] POS_LEN1 = 16'h0011;
  localparam logic [15:0] POS_DATA0 = 16'h0012;

  // ****************************************************************
  // Field values and lengths
  // ****************************************************************
  localparam logic [7:0] DFH_FIRST = 8'h11;
  localparam logic [7:0] DFH_LAST = 8'h00;
  localparam logic [7:0] SVC_HK = 8'h03;
  localparam logic [7:0] SUB_HK_ENABLE = 8'h05;
  localparam logic [7:0] SUB_HK_DISABLE = 8'h06;
  localparam logic [7:0] SVC_MEMORY = 8'h06;
  localparam logic [7:0] SUB_MEMORY_LOAD = 8'h02;
  localparam logic [7:0] HK_SID_VALUE = 8'h01;
  localparam logic [7:0] MEM_SELECTOR_VALUE = 8'hc0;
  localparam logic [7:0] MEM_BLOCKS_VALUE = 8'h01;
  localparam logic [15:0] HK_PKT_LEN = 16'h000e;
  localparam logic [15:0] LOAD_PKT_BASE = 16'h0014;
  localparam logic [15:0] LOAD_MAX_WORDS = 16'h0071;

  // ****************************************************************
  // CRC and values after reset
  // ****************************************************************
  localparam logic [15:0] CRC_INIT = 16'hffff;
  localparam logic [15:0] CRC_POLY = 16'h1021;
  localparam logic RST_HK_ENABLED = 1'b0;
  localparam logic [31:0] DEF_CONFIRM_ADDR = 32'hffff_fffe;

  typedef enum {TCHK_NORMAL, TCHK_UPLOAD} tchk_mode_t;

  typedef struct packed {
    logic [31:0] addr;
    logic [15:0] data;
  } tchk_ram_word_t;

endpackage : tchk_pkg

// *** tb/tchk_interp_tb.sv ***
/*
  Self-checking bench of the telecommand interpreter: housekeeping
  switching, loads with staging stalls, commit and anomalies. Assumes
  the package, design and sender model are compiled before it.
*/
`timescale 1ns/1ns
module tchk_interp_tb;
  import tchk_pkg::*;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic rx_valid, rx_first, rx_last, rx_ready;
  logic [7:0] rx_data;
  logic upload_enter = 1'b0;
  logic [7:0] upload_blocks = 8'h00;
  logic hk_on, up_on, wr_valid, commit, rep_inc, rep_done, rep_anom;
  logic wr_ready = 1'b1;
  tchk_ram_word_t wr_word;
  int n_mismatch, n_compared, cycles, nb;
  int n_inc, n_done, n_anom, n_commit, n_words;
  logic [31:0] ld_base;

  tchk_interp dut_u (
    .clk(clk), .resetn(resetn), .rx_valid(rx_valid), .rx_data(rx_data),
    .rx_first(rx_first), .rx_last(rx_last), .rx_ready(rx_ready),
    .upload_enter(upload_enter), .upload_blocks(upload_blocks),
    .hk_report_enabled(hk_on), .upload_active(up_on),
    .ram_wr_valid(wr_valid), .ram_wr_word(wr_word),
    .ram_wr_ready(wr_ready), .eeprom_commit(commit),
    .report_incorrect_cmd(rep_inc), .report_upload_done(rep_done),
    .report_anomaly(rep_anom)
  );
  tchk_tc_sender snd_u (
    .clk(clk), .rx_ready(rx_ready), .rx_valid(rx_valid),
    .rx_data(rx_data), .rx_first(rx_first), .rx_last(rx_last)
  );

  initial forever #25 clk = ~clk;

  // ****************************************************************
  // Watchers, counting pulses and staged words between edges
  // ****************************************************************
  always @(negedge clk) begin
    n_inc += rep_inc;
    n_done += rep_done;
    n_anom += rep_anom;
    n_commit += commit;
    if (wr_valid && wr_ready) begin
      chk(wr_word, {ld_base + n_words, n_words[7:0], ~n_words[7:0]});
      n_words++;
    end
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      stop_test();
    end
  end

  task automatic stop_test();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : stop_test

  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk

  task automatic rep(input int inc, input int done, input int anom);
    chk(n_inc, inc);
    chk(n_done, done);
    chk(n_commit, done);
    chk(n_anom, anom);
    n_inc = 0;
    n_done = 0;
    n_commit = 0;
    n_anom = 0;
  endtask : rep

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  task automatic put(input logic [47:0] v, input int k);
    for (int i = k - 1; i >= 0; i--) begin
      snd_u.body[nb] = v[8 * i +: 8];
      nb++;
    end
  endtask : put

  task automatic hk(input logic [7:0] sub, pad, hk_structure_id, input logic bad);
    nb = 0;
    put({DFH_FIRST, SVC_HK, sub, DFH_LAST, pad, hk_structure_id}, 6);
    snd_u.send(nb, bad);
    tick(2);
  endtask : hk

  task automatic load(input logic [31:0] a, input int n,
                      input logic [7:0] sel, input logic bad);
    nb = 0;
    ld_base = a;
    n_words = 0;
    put({DFH_FIRST, SVC_MEMORY, SUB_MEMORY_LOAD, DFH_LAST, sel,
         MEM_BLOCKS_VALUE}, 6);
    put({a, 16'(n)}, 6);
    for (int i = 0; i < n; i++) put({i[7:0], ~i[7:0]}, 2);
    snd_u.send(nb, bad);
    tick(2);
  endtask : load

  task automatic enter(input logic [7:0] blocks);
    upload_enter = 1'b1;
    upload_blocks = blocks;
    tick(1);
    upload_enter = 1'b0;
    tick(1);
  endtask : enter

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_hk();
    chk(hk_on, RST_HK_ENABLED);
    hk(SUB_HK_ENABLE, 8'h5a, HK_SID_VALUE, 1'b0);
    chk(hk_on, 1'b1);
    hk(SUB_HK_DISABLE, 8'ha5, HK_SID_VALUE, 1'b0);
    chk(hk_on, 1'b0);
    hk(SUB_HK_ENABLE, 8'h00, 8'h02, 1'b0);
    chk(hk_on, 1'b0);
    hk(SUB_HK_ENABLE, 8'h00, HK_SID_VALUE, 1'b1);
    chk(hk_on, 1'b0);
    hk(8'h07, 8'h00, HK_SID_VALUE, 1'b0);
    rep(0, 0, 0);
  endtask : t_hk

  task automatic t_upload();
    load(32'h0000_8000, 2, MEM_SELECTOR_VALUE, 1'b0);
    rep(1, 0, 0);
    chk(n_words, 0);
    enter(8'h02);
    chk(up_on, 1'b1);
    hk(SUB_HK_ENABLE, 8'h00, HK_SID_VALUE, 1'b0);
    rep(1, 0, 0);
    chk(hk_on, 1'b0);
    wr_ready = 1'b0;
    fork
      load(32'h0001_0000, 4, MEM_SELECTOR_VALUE, 1'b0);
      begin
        tick(40);
        chk(n_words, 0);
        wr_ready = 1'b1;
      end
    join
    chk(n_words, 4);
    load(32'h0002_0000, 113, MEM_SELECTOR_VALUE, 1'b0);
    chk(n_words, 113);
    rep(0, 0, 0);
    load(DEF_CONFIRM_ADDR, 1, MEM_SELECTOR_VALUE, 1'b0);
    chk(n_words, 0);
    rep(0, 1, 0);
    chk(up_on, 1'b0);
  endtask : t_upload

  task automatic t_fail();
    enter(8'h02);
    load(32'h0000_0100, 1, MEM_SELECTOR_VALUE, 1'b0);
    load(DEF_CONFIRM_ADDR, 1, MEM_SELECTOR_VALUE, 1'b0);
    rep(0, 0, 1);
    chk(up_on, 1'b0);
    enter(8'h01);
    load(32'h0000_0200, 1, 8'hc1, 1'b0);
    rep(0, 0, 0);
    chk(up_on, 1'b1);
    load(32'h0000_0200, 1, MEM_SELECTOR_VALUE, 1'b1);
    rep(0, 0, 1);
    enter(8'h01);
    load(32'h0000_0300, 1, MEM_SELECTOR_VALUE, 1'b0);
    load(32'h0000_0400, 1, MEM_SELECTOR_VALUE, 1'b0);
    rep(0, 0, 1);
  endtask : t_fail

  initial begin
    repeat (3) @(posedge clk);
    #1;
    resetn = 1'b1;
    tick(4);
    t_hk();
    t_upload();
    t_fail();
    stop_test();
  end
endmodule : tchk_interp_tb

// *** tb/tchk_tc_sender.sv ***
/*
  Sender model of the command link: frames a body with header, running
  count and CRC16, and offers it byte by byte. Assumes clk is shared
  with the interpreter and that callers start a send just after an edge.
*/
`timescale 1ns/1ns
module tchk_tc_sender (
  input wire logic clk,
  input wire logic rx_ready,
  output logic rx_valid,
  output logic [7:0] rx_data,
  output logic rx_first,
  output logic rx_last
);
  import tchk_pkg::*;
  logic [7:0] body [0:255];
  logic [7:0] pkt [0:263];
  logic [11:0] seq = 12'h000;

  initial begin
    rx_valid = 1'b0;
    rx_data = 8'h00;
    rx_first = 1'b0;
    rx_last = 1'b0;
  end

  function automatic logic [15:0] crc_step(input logic [15:0] c,
                                           input logic [7:0] d);
    logic [15:0] r;
    r = c ^ {d, 8'h00};
    for (int i = 0; i < 8; i++) begin
      r = r[15] ? {r[14:0], 1'b0} ^ CRC_POLY : {r[14:0], 1'b0};
    end
    return r;
  endfunction : crc_step

  // ****************************************************************
  // Packet framing and byte handshake
  // ****************************************************************
  task automatic send(input int n, input logic bad);
    logic [15:0] crc;
    logic t;
    pkt[0] = 8'h1d;
    pkt[1] = 8'h1c;
    pkt[2] = {4'hc, seq[11:8]};
    pkt[3] = seq[7:0];
    pkt[4] = 8'h00;
    pkt[5] = 8'(n + 1);
    for (int i = 0; i < n; i++) pkt[6 + i] = body[i];
    crc = CRC_INIT;
    for (int i = 0; i < n + 6; i++) crc = crc_step(crc, pkt[i]);
    if (bad) crc = ~crc;
    pkt[n + 6] = crc[15:8];
    pkt[n + 7] = crc[7:0];
    seq = seq + 12'h001;
    for (int i = 0; i < n + 8; i++) begin
      rx_valid = 1'b1;
      rx_data = pkt[i];
      rx_first = (i == 0);
      rx_last = (i == n + 7);
      // Ready is registered, so its value before the edge is what counts
      do begin
        @(negedge clk);
        t = rx_ready;
        @(posedge clk);
      end while (!t);
      #1;
    end
    rx_valid = 1'b0;
    rx_first = 1'b0;
    rx_last = 1'b0;
    rx_data = ~rx_data;
  endtask : send
endmodule : tchk_tc_sender
